// >>> src/supply_monitor_ctrl.sv
// Supply monitor control: register file, sticky supply-low flag, hold-off timer, interrupt
`default_nettype none
`include "supply_monitor_cfg.svh"

module supply_monitor_ctrl
    import supply_monitor_pkg::*;
#(
    parameter int unsigned HOLDOFF_CYCLES =
        (`HOLDOFF_MS * `NS_PER_MS) / `CLK_PERIOD_NS,
    parameter int unsigned GLITCH_CYCLES = `GLITCH_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire reg_req_t req,
    output logic [7:0] rdata,
    input wire compare_in_t cmp_in,
    output analog_ctrl_t analog_ctrl,
    output logic irq,
    output logic [15:0] irq_vector
);
    localparam int unsigned HW = $clog2(HOLDOFF_CYCLES + 1);
    localparam logic [HW-1:0] HOLDOFF_LAST = HW'(HOLDOFF_CYCLES - 1);
    localparam logic [7:0] CTRL_RST = `CTRL_RESET;

    // Filtered comparator levels
    logic analog_ok;
    logic digital_ok;
    logic supply_ok;

    // Control/status state
    logic unused_bit_r;
    logic flag_r;
    logic flag_nxt;
    logic [2:0] trip_r;
    logic fault_src_r;
    logic enable_r;
    logic [HW-1:0] holdoff_cnt_r;
    logic holdoff_done;

    // Interrupt registers
    logic [`EVT_W-1:0] evt_sticky_r;
    logic [`EVT_W-1:0] evt_status;
    logic [`EVT_W-1:0] irq_enable_r;
    logic low_event;
    logic recover_event;

    // Output flops
    logic [7:0] rdata_r;
    logic irq_r;
    logic [15:0] irq_vector_r;
    analog_ctrl_t analog_ctrl_r;

    // Decoded strobes
    logic wr_ctrl;
    logic wr_ie;
    logic wr_clr;
    logic sw_set;
    logic sw_clear;

    // Both comparators go through their own filter so a spike cannot reach the flag
    glitch_filter #(
        .STABLE_CYCLES(GLITCH_CYCLES),
        .RESET_LEVEL(1'b1)
    ) u_analog_filter (
        .clk(clk),
        .nrst(nrst),
        .raw(cmp_in.analog_supply_compare),
        .clean(analog_ok)
    );

    glitch_filter #(
        .STABLE_CYCLES(GLITCH_CYCLES),
        .RESET_LEVEL(1'b1)
    ) u_digital_filter (
        .clk(clk),
        .nrst(nrst),
        .raw(cmp_in.digital_supply_compare),
        .clean(digital_ok)
    );

    // A disabled monitor has no valid comparators, so it reports a good supply
    assign supply_ok = !enable_r || (analog_ok && digital_ok);

    // Register port decode
    assign wr_ctrl = req.wr && (req.addr == `CTRL_STATUS_ADDR);
    assign wr_ie = req.wr && (req.addr == `IRQ_ENABLE_ADDR);
    assign wr_clr = req.wr && (req.addr == `EVT_CLEAR_ADDR);
    assign sw_set = wr_ctrl && req.wdata[`FLAG_BIT];
    assign sw_clear = wr_ctrl && !req.wdata[`FLAG_BIT];

    // Hold-off expires on its last count while the supply is still good
    assign holdoff_done = flag_r && supply_ok && (holdoff_cnt_r == HOLDOFF_LAST);

    // Flag next value: hardware set beats any software clear
    always_comb begin
        flag_nxt = flag_r;
        if (!supply_ok) begin
            flag_nxt = 1'b1;
        end else if (sw_set) begin
            flag_nxt = 1'b1;
        end else if (sw_clear) begin
            flag_nxt = 1'b0; // Only reached with good supply
        end else if (holdoff_done) begin
            flag_nxt = 1'b0;
        end
    end

    // Events for the sticky status register
    assign low_event = flag_nxt && !flag_r;
    assign recover_event = holdoff_done && !sw_set;

    // Supply-low flag
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flag_r <= CTRL_RST[`FLAG_BIT];
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // Hold-off counter runs only while the flag waits on a good supply
    always_ff @(posedge clk) begin
        if (!nrst) begin
            holdoff_cnt_r <= '0;
        end else if (!supply_ok || !flag_nxt) begin
            holdoff_cnt_r <= '0; // Drop during wait restarts it
        end else begin
            holdoff_cnt_r <= holdoff_cnt_r + 1'b1;
        end
    end

    // Software settings: trip point and enable; the unused bit only loads its reset value
    always_ff @(posedge clk) begin
        if (!nrst) begin
            trip_r <= CTRL_RST[`TRIP_MSB:`TRIP_LSB];
            enable_r <= CTRL_RST[`ENABLE_BIT];
            unused_bit_r <= CTRL_RST[7];
        end else if (wr_ctrl) begin
            trip_r <= req.wdata[`TRIP_MSB:`TRIP_LSB];
            enable_r <= req.wdata[`ENABLE_BIT];
        end
    end

    // Fault source follows whichever supply is low; analog wins a tie
    always_ff @(posedge clk) begin
        if (!nrst) begin
            fault_src_r <= CTRL_RST[`FAULT_SRC_BIT];
        end else if (!supply_ok) begin
            fault_src_r <= !analog_ok;
        end
    end

    // Settings to the analog side; all eight 3-bit trip codes pass through unchanged
    always_ff @(posedge clk) begin
        if (!nrst) begin
            analog_ctrl_r <= '{trip_select: CTRL_RST[`TRIP_MSB:`TRIP_LSB],
                               monitor_enable_bit: CTRL_RST[`ENABLE_BIT]};
        end else begin
            analog_ctrl_r <= '{trip_select: trip_r, monitor_enable_bit: enable_r};
        end
    end

    // Sticky events; a new event in the clear cycle survives the clear
    always_ff @(posedge clk) begin
        if (!nrst) begin
            evt_sticky_r <= '0;
        end else begin
            evt_sticky_r <= (evt_sticky_r & ~(wr_clr ? req.wdata[`EVT_W-1:0] : '0))
                | {recover_event, 1'b0, low_event};
        end
    end

    // Status view: the flag bit is live, the two event bits are sticky
    assign evt_status = (evt_sticky_r & `EVT_STICKY_MASK)
        | ({`EVT_W{flag_r}} & ~`EVT_STICKY_MASK);

    // Interrupt enable register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_enable_r <= `IRQ_ENABLE_RESET;
        end else if (wr_ie) begin
            irq_enable_r <= req.wdata[`EVT_W-1:0];
        end
    end

    // Level interrupt; the flag itself is never touched by the enable
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(evt_status & irq_enable_r);
        end
    end

    // Vector address stands beside the request for the core's branch
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_vector_r <= `IRQ_VECTOR;
        end else begin
            irq_vector_r <= `IRQ_VECTOR;
        end
    end

    // Read data stands only in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_r <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                `CTRL_STATUS_ADDR: begin
                    rdata_r <= {unused_bit_r, supply_ok, flag_r, trip_r,
                                fault_src_r, enable_r};
                end
                `IRQ_ENABLE_ADDR: begin
                    rdata_r <= {5'h00, irq_enable_r};
                end
                `EVT_STATUS_ADDR: begin
                    rdata_r <= {5'h00, evt_status};
                end
                default: begin
                    rdata_r <= 8'h00; // Unmapped and write-only read as zero
                end
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign rdata = rdata_r;
    assign irq = irq_r;
    assign irq_vector = irq_vector_r;
    assign analog_ctrl = analog_ctrl_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_ctrl_read;
        req.rd && (req.addr == `CTRL_STATUS_ADDR);
    endsequence

    sequence s_holdoff_expire;
        holdoff_done && !sw_set;
    endsequence

    property p_cmp_bit;
        s_ctrl_read |=> (rdata[`CMP_BIT] == $past(supply_ok));
    endproperty
    a_cmp_bit: assert property (p_cmp_bit)
        else $error("comparator bit does not match the supply state");

    property p_flag_set;
        (enable_r && !(analog_ok && digital_ok)) |=> flag_r;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("low comparator did not set the supply-low flag");

    property p_holdoff_clear;
        s_holdoff_expire |=> !flag_r && (holdoff_cnt_r == '0);
    endproperty
    a_holdoff_clear: assert property (p_holdoff_clear)
        else $error("flag not cleared when hold-off expired");

    property p_no_early_clear;
        (flag_r && !wr_ctrl && holdoff_cnt_r != HOLDOFF_LAST) |=> flag_r;
    endproperty
    a_no_early_clear: assert property (p_no_early_clear)
        else $error("flag cleared before the hold-off count ended");

    property p_clear_ignored;
        (sw_clear && !supply_ok) |=> flag_r;
    endproperty
    a_clear_ignored: assert property (p_clear_ignored)
        else $error("software cleared the flag while a supply was low");

    property p_irq_follows;
        (flag_r && irq_enable_r[`EVT_FLAG_BIT]) |=> irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("enabled flag did not raise the interrupt");

    property p_irq_gated;
        ((evt_status & irq_enable_r) == '0) |=> !irq;
    endproperty
    a_irq_gated: assert property (p_irq_gated)
        else $error("interrupt raised with no enabled status bit");

    property p_trip_write;
        wr_ctrl |=> (trip_r == $past(req.wdata[`TRIP_MSB:`TRIP_LSB]))
            ##1 (analog_ctrl.trip_select == $past(trip_r));
    endproperty
    a_trip_write: assert property (p_trip_write)
        else $error("trip selection not taken from the write");

    property p_fault_src;
        (enable_r && !analog_ok) |=> fault_src_r;
    endproperty
    a_fault_src: assert property (p_fault_src)
        else $error("analog fault not reported as the source");

    property p_enable_write;
        wr_ctrl |=> (enable_r == $past(req.wdata[`ENABLE_BIT]));
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("monitor enable not taken from the write");

    property p_vector;
        irq |-> (irq_vector == `IRQ_VECTOR);
    endproperty
    a_vector: assert property (p_vector)
        else $error("wrong vector beside the interrupt");

    property p_restart;
        (flag_r && !supply_ok) |=> (holdoff_cnt_r == '0) && flag_r;
    endproperty
    a_restart: assert property (p_restart)
        else $error("hold-off not restarted by a supply drop");

endmodule : supply_monitor_ctrl

`default_nettype wire

// >>> pkg/supply_monitor_cfg.svh
// Supply monitor control: register offsets, field positions, reset values and timing counts
`ifndef SUPPLY_MONITOR_CFG_SVH
`define SUPPLY_MONITOR_CFG_SVH

// Register offsets on the 8-bit register port
`define CTRL_STATUS_ADDR 8'hdf
`define IRQ_ENABLE_ADDR 8'hd0
`define EVT_STATUS_ADDR 8'hd1
`define EVT_CLEAR_ADDR 8'hd2

// Control/status field positions
`define CMP_BIT 6
`define FLAG_BIT 5
`define TRIP_MSB 4
`define TRIP_LSB 2
`define FAULT_SRC_BIT 1
`define ENABLE_BIT 0

// Control/status reset value; bit 7 is unused and reads as its reset value
`define CTRL_RESET 8'hdc

// Event status / enable / clear layout
`define EVT_LOW_BIT 0
`define EVT_FLAG_BIT 1
`define EVT_RECOVER_BIT 2
`define EVT_W 3
`define EVT_STICKY_MASK 3'h5
`define IRQ_ENABLE_RESET 3'h0

// Timing
`define CLK_PERIOD_NS 8
`define HOLDOFF_MS 256
`define NS_PER_MS 1000000
`define GLITCH_CYCLES 4

// Interrupt vector handed to the core with the request
`define IRQ_VECTOR 16'h0043

`endif

// >>> pkg/supply_monitor_pkg.sv
// Supply monitor control: shared types
`default_nettype none

package supply_monitor_pkg;

    // One register port request, sampled on the rising clock edge
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Settings driven to the analog comparators
    typedef struct packed {
        logic [2:0] trip_select;
        logic monitor_enable_bit;
    } analog_ctrl_t;

    // Comparator outputs coming back from the analog side
    typedef struct packed {
        logic analog_supply_compare;
        logic digital_supply_compare;
    } compare_in_t;

endpackage : supply_monitor_pkg

`default_nettype wire

// >>> src/glitch_filter.sv
// Glitch filter: passes a level only after it has been stable for a set number of cycles
`default_nettype none

module glitch_filter #(
    parameter int unsigned STABLE_CYCLES = 4,
    parameter bit RESET_LEVEL = 1'b1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic raw,
    output logic clean
);
    localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(STABLE_CYCLES - 1);

    logic [CW-1:0] stable_cnt_r;
    logic clean_r;

    // A differing level must persist STABLE_CYCLES clocks before it is passed on
    always_ff @(posedge clk) begin
        if (!nrst) begin
            clean_r <= RESET_LEVEL;
            stable_cnt_r <= '0;
        end else if (raw == clean_r) begin
            stable_cnt_r <= '0; // Short pulse: restart the wait
        end else if (stable_cnt_r == LAST) begin
            clean_r <= raw;
            stable_cnt_r <= '0;
        end else begin
            stable_cnt_r <= stable_cnt_r + 1'b1;
        end
    end

    assign clean = clean_r;

    property p_glitch_hold;
        @(posedge clk) disable iff (!nrst)
        (clean_r != $past(clean_r)) |-> ($past(stable_cnt_r) == LAST);
    endproperty
    a_glitch_hold: assert property (p_glitch_hold)
        else $error("filtered level changed before the stable count completed");

endmodule : glitch_filter

`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking testbench for the supply monitor control block
`default_nettype none
`include "supply_monitor_cfg.svh"

module tb_top
    import supply_monitor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Short counts keep the hold-off run to a few dozen cycles
    localparam int HOLD = 20;
    localparam int GL = 3;

    logic clk;
    logic nrst;
    reg_req_t req;
    logic [7:0] rdata;
    compare_in_t cmp_in;
    analog_ctrl_t analog_ctrl;
    logic irq;
    logic [15:0] irq_vector;
    int fail_count = 0;
    int checks = 0;
    int seed = 32'hbd3ef559;
    int n;
    logic [7:0] rd_val;
    logic [7:0] rnd;
    logic [2:0] code;

    supply_monitor_ctrl #(.HOLDOFF_CYCLES(HOLD), .GLITCH_CYCLES(GL)) dut (
        .clk(clk),
        .nrst(nrst),
        .req(req),
        .rdata(rdata),
        .cmp_in(cmp_in),
        .analog_ctrl(analog_ctrl),
        .irq(irq),
        .irq_vector(irq_vector)
    );

    // Free-running 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Expected control/status byte; bit 7 always reads back as one
    function automatic logic [7:0] ctrl_exp(input logic cmp, input logic flag,
                                            input logic [2:0] trip, input logic src,
                                            input logic en);
        return {1'b1, cmp, flag, trip, src, en};
    endfunction

    task automatic end_sim();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // One-cycle write strobe; a cycle of gap before each request keeps drives unique
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so sample it there
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        reg_rd(a, rd_val);
        chk_val({8'h00, rd_val}, {8'h00, exp}, what);
    endtask

    task automatic set_cmp(input logic ana, input logic dig);
        @(posedge clk);
        cmp_in.analog_supply_compare <= ana;
        cmp_in.digital_supply_compare <= dig;
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge clk);
    endtask

    // Watchdog sized well above the expected few hundred cycles
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        end_sim();
    end

    initial begin
        nrst = 1'b0;
        req = '0;
        cmp_in = 2'b11;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        chk_bit(irq, 1'b0, "irq after reset");
        chk_val(irq_vector, 16'h0043, "vector");
        chk_val({12'h0, analog_ctrl}, 16'h000e, "analog ctrl reset");
        chk_rd(`CTRL_STATUS_ADDR, `CTRL_RESET, "ctrl reset");
        chk_rd(`IRQ_ENABLE_ADDR, 8'h00, "irq enable reset");
        chk_rd(`EVT_STATUS_ADDR, 8'h00, "status reset");

        // Trip codes 0 to 4, then one random code; read-only bits get random data
        for (int c = 0; c < 6; c++) begin
            rnd = $random(seed);
            code = (c < 5) ? c[2:0] : rnd[4:2];
            reg_wr(`CTRL_STATUS_ADDR, {rnd[7:6], 1'b0, code, rnd[1], 1'b1});
            @(posedge clk);
            #1;
            chk_val({12'h0, analog_ctrl}, {12'h0, code, 1'b1}, "trip out");
            chk_rd(`CTRL_STATUS_ADDR, ctrl_exp(1'b1, 1'b0, code, 1'b0, 1'b1), "trip rd");
        end
        reg_wr(`CTRL_STATUS_ADDR, 8'h05);
        reg_wr(`IRQ_ENABLE_ADDR, 8'h02);

        // Pulses shorter than the filter span must leave the flag alone
        for (int g = 0; g < 4; g++) begin
            n = 1 + ($unsigned($random(seed)) % (GL - 1));
            set_cmp(g[0], ~g[0]);
            idle(n - 1);
            set_cmp(1'b1, 1'b1);
            idle(GL + 3);
            reg_rd(`CTRL_STATUS_ADDR, rd_val);
            chk_bit(rd_val[5], 1'b0, "glitch flag");
            chk_bit(irq, 1'b0, "glitch irq");
        end

        // Analog fault sets the flag; a clear attempt while low is ignored
        set_cmp(1'b0, 1'b1);
        idle(GL + 3);
        #1;
        chk_bit(irq, 1'b1, "fault irq");
        chk_rd(`CTRL_STATUS_ADDR, ctrl_exp(1'b0, 1'b1, 3'd1, 1'b1, 1'b1), "ana fault");
        reg_wr(`CTRL_STATUS_ADDR, 8'h05);
        chk_rd(`CTRL_STATUS_ADDR, ctrl_exp(1'b0, 1'b1, 3'd1, 1'b1, 1'b1), "clr low");
        chk_rd(`EVT_STATUS_ADDR, 8'h03, "status set");

        // Digital fault names the digital source
        set_cmp(1'b1, 1'b0);
        idle(GL + 3);
        chk_rd(`CTRL_STATUS_ADDR, ctrl_exp(1'b0, 1'b1, 3'd1, 1'b0, 1'b1), "dig fault");

        // A drop mid hold-off restarts the full count
        set_cmp(1'b1, 1'b1);
        idle(8);
        set_cmp(1'b1, 1'b0);
        idle(GL + 3);
        set_cmp(1'b1, 1'b1);
        idle(GL + HOLD - 6);
        reg_rd(`CTRL_STATUS_ADDR, rd_val);
        chk_bit(rd_val[5], 1'b1, "restart hold");
        // Handler-style poll: keep reading the flag until it drops, bounded by the hold-off
        for (int p = 0; p < HOLD && rd_val[5]; p++) begin
            reg_rd(`CTRL_STATUS_ADDR, rd_val);
        end
        chk_bit(rd_val[5], 1'b0, "poll clr");
        chk_rd(`CTRL_STATUS_ADDR, ctrl_exp(1'b1, 1'b0, 3'd1, 1'b0, 1'b1), "auto clr");
        chk_bit(irq, 1'b0, "irq after clr");
        chk_rd(`EVT_STATUS_ADDR, 8'h05, "status recover");

        // Sticky clear, read-only status, unmapped and write-only reads
        reg_wr(`EVT_CLEAR_ADDR, 8'h07);
        chk_rd(`EVT_STATUS_ADDR, 8'h00, "status cleared");
        reg_wr(`EVT_STATUS_ADDR, 8'h07);
        chk_rd(`EVT_STATUS_ADDR, 8'h00, "status ro");
        chk_rd(8'h55, 8'h00, "unmapped");
        chk_rd(`EVT_CLEAR_ADDR, 8'h00, "clear wo");

        // Masked flag raises no interrupt; software set and clear with good supply
        reg_wr(`IRQ_ENABLE_ADDR, 8'h00);
        reg_wr(`CTRL_STATUS_ADDR, 8'h25);
        idle(1);
        #1;
        chk_bit(irq, 1'b0, "masked irq");
        reg_rd(`CTRL_STATUS_ADDR, rd_val);
        chk_bit(rd_val[5], 1'b1, "sw set");
        reg_wr(`IRQ_ENABLE_ADDR, 8'h02);
        idle(1);
        #1;
        chk_bit(irq, 1'b1, "unmasked irq");
        reg_wr(`CTRL_STATUS_ADDR, 8'h05);
        reg_rd(`CTRL_STATUS_ADDR, rd_val);
        chk_bit(rd_val[5], 1'b0, "sw clear");

        // Disabled monitor ignores low supplies
        reg_wr(`CTRL_STATUS_ADDR, 8'h04);
        set_cmp(1'b0, 1'b0);
        idle(GL + 3);
        reg_rd(`CTRL_STATUS_ADDR, rd_val);
        chk_val({14'h0, rd_val[6:5]}, 16'h0002, "disabled");
        chk_bit(irq, 1'b0, "disabled irq");
        chk_val({12'h0, analog_ctrl}, 16'h0002, "disabled out");
        end_sim();
    end

endmodule // tb_top

`default_nettype wire
